// ### dv/fuser_plant_model.sv
// stand-in for thermistor converter, sensor wiring and hardware comparator
`timescale 1ns/1ps
module fuser_plant_model #(
    parameter int CONV_GAP = 2
) (
    input  wire logic       mclk_i,
    input  wire logic [9:0] target_temp_i,
    input  wire logic       wire_cut_i,
    input  wire logic       overheat_trip_i,
    output logic [9:0]      roller_temp_o,
    output logic            temp_valid_o,
    output logic            thermistor_fault_o,
    output logic            hw_overheat_cut_o
);
    int gap_q;
    initial begin
        gap_q = 0;
        roller_temp_o = 10'h000;
        temp_valid_o = 1'b0;
        thermistor_fault_o = 1'b0;
        hw_overheat_cut_o = 1'b0;
    end
    // fresh conversion every CONV_GAP cycles, scrambled data between samples
    always @(negedge mclk_i) begin
        thermistor_fault_o <= wire_cut_i;
        hw_overheat_cut_o <= overheat_trip_i;
        if (gap_q >= CONV_GAP - 1) begin
            gap_q <= 0;
            temp_valid_o <= 1'b1;
            roller_temp_o <= target_temp_i;
        end else begin
            gap_q <= gap_q + 1;
            temp_valid_o <= 1'b0;
            roller_temp_o <= ~roller_temp_o;
        end
    end
endmodule

// ### dv/test_fuser_temperature_supervisor.sv
// self-checking bench for the fuser temperature supervisor
`timescale 1ns/1ps
`include "fuser_map.svh"
module test_fuser_temperature_supervisor;
    localparam logic [9:0] SP = `FUSER_SETPOINT_DEF;
    localparam logic [9:0] OH = `FUSER_OVERHEAT_DEF;
    localparam int         WARM_N = 50;
    localparam int         SPAN_N = 30;
    logic       mclk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b0, cut = 1'b0, trip = 1'b0;
    logic [9:0] target = 10'h000, temp;
    logic       valid, th_fault, hw_cut, heat_n, relay, ac_cut, stop, fault, ready, seen;
    logic [3:0] err;
    logic [3:0] exp_q[$];
    int         fail_count = 0, checks = 0, seed = 36;

    fuser_plant_model fuser_plant_model_i (.mclk_i(mclk_i), .target_temp_i(target),
        .wire_cut_i(cut), .overheat_trip_i(trip), .roller_temp_o(temp),
        .temp_valid_o(valid), .thermistor_fault_o(th_fault), .hw_overheat_cut_o(hw_cut));
    fuser_temperature_supervisor #(.OVER_CYC(32'd20), .WARM_CYC(32'd50),
        .UNDER_CYC(32'd30), .ABOVE_CYC(32'd30)) fuser_temperature_supervisor_i (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .roller_temp_i(temp),
        .temp_valid_i(valid), .thermistor_fault_i(th_fault), .hw_overheat_cut_i(hw_cut),
        .heater_on_n_o(heat_n), .power_relay_on_o(relay), .ac_cut_off_o(ac_cut),
        .printer_stop_o(stop), .fault_o(fault), .err_code_o(err), .warm_ready_o(ready));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    // compare one status bit
    task automatic check_bit(input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t status bit %b expected %b", $time, g, e);
        end
    endtask
    // compare the error code
    task automatic check_err(input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t error code %h expected %h", $time, g, e);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // synchronous reset, far side back to quiet
    task automatic do_reset(input int n);
        srst_i = 1'b1;
        ce_i = 1'b1;
        cut = 1'b0;
        trip = 1'b0;
        target = 10'h000;
        hold(n);
        srst_i = 1'b0;
    endtask
    // bounded wait for the latched fault, optionally stuttering the clock enable
    task automatic wait_fault(input int bound, input bit jitter);
        int i;
        i = 0;
        while (fault !== 1'b1 && i < bound) begin
            if (jitter)
                ce_i = ($unsigned($random(seed)) % 4) != 0;
            hold(1);
            i++;
        end
        ce_i = 1'b1;
        check_bit(1'b1, fault);
        hold(2);
    endtask

    // monitor: on each new fault take the oldest expectation and check outputs
    always @(negedge mclk_i) begin
        if (srst_i === 1'b1) begin
            seen = 1'b0;
        end else if (fault === 1'b1 && seen !== 1'b1) begin
            seen = 1'b1;
            check_err(exp_q.size() > 0 ? exp_q.pop_front() : 4'hF, err);
            check_bit(1'b0, relay);
            check_bit(1'b1, ac_cut);
            check_bit(1'b1, stop);
            check_bit(1'b1, heat_n);
        end
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        results();
    end

    initial begin
        do_reset(16);
        hold(3);
        check_bit(1'b1, heat_n);
        check_bit(1'b1, relay);
        check_bit(1'b0, fault);
        check_err(`FUSER_ERR_NONE, err);
        // open sensor beats comparator cut when both arrive together
        cut = 1'b1;
        trip = 1'b1;
        exp_q.push_back(`FUSER_ERR_SENSOR);
        wait_fault(10, 1'b0);
        hold(5);
        check_err(`FUSER_ERR_SENSOR, err);
        do_reset(3);
        trip = 1'b1;
        exp_q.push_back(`FUSER_ERR_HWOVER);
        wait_fault(10, 1'b0);
        // never reaching set point
        do_reset(3);
        target = SP - 10'h001;
        hold(10);
        check_bit(1'b0, heat_n);
        hold(WARM_N / 2);
        check_bit(1'b0, fault);
        exp_q.push_back(`FUSER_ERR_WARMUP);
        wait_fault(WARM_N + 20, 1'b0);
        // reach set point, then sag below it
        do_reset(3);
        target = SP;
        hold(10);
        check_bit(1'b1, ready);
        check_bit(1'b1, heat_n);
        target = SP - 10'h001 - 10'($unsigned($random(seed)) % 16);
        hold(SPAN_N / 2);
        check_bit(1'b0, heat_n);
        check_bit(1'b0, fault);
        exp_q.push_back(`FUSER_ERR_UNDER);
        wait_fault(SPAN_N + 20, 1'b0);
        // stuck above set point but under the limit, stuttering enable
        do_reset(3);
        target = SP + 10'h001 + 10'($unsigned($random(seed)) % 24);
        hold(10);
        check_bit(1'b1, heat_n);
        check_bit(1'b0, fault);
        exp_q.push_back(`FUSER_ERR_OVERSP);
        wait_fault(3 * SPAN_N + 40, 1'b1);
        // one below the limit is tolerated, the limit itself trips at once
        do_reset(3);
        target = SP;
        hold(10);
        target = OH - 10'h001;
        hold(6);
        check_bit(1'b0, fault);
        target = OH;
        exp_q.push_back(`FUSER_ERR_LIMIT);
        wait_fault(10, 1'b0);
        checks++;
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("[ERR] %0t expected faults never appeared", $time);
        end
        results();
    end
endmodule

// ### include/fuser_map.svh
// constant map for the fuser temperature supervisor
`ifndef FUSER_MAP_SVH
`define FUSER_MAP_SVH
`define FUSER_TEMP_W        10
`define FUSER_SETPOINT_DEF  10'h0A0
`define FUSER_OVERHEAT_DEF  10'h0B9
`define FUSER_OVER_CYC_DEF  100000
`define FUSER_WARM_CYC_DEF  3000000
`define FUSER_UNDER_CYC_DEF 1000000
`define FUSER_ABOVE_CYC_DEF 1000000
`define FUSER_CNT_W         32
`define FUSER_ERR_W         4
`define FUSER_ERR_NONE      4'h0
`define FUSER_ERR_SENSOR    4'h1
`define FUSER_ERR_OVERTO    4'h2
`define FUSER_ERR_WARMUP    4'h3
`define FUSER_ERR_UNDER     4'h4
`define FUSER_ERR_OVERSP    4'h5
`define FUSER_ERR_HWOVER    4'h6
`define FUSER_ERR_LIMIT     4'h7
`endif

// ### include/fuser_pkg.sv
// types for the fuser temperature supervisor
package fuser_pkg;
    typedef enum logic [1:0] {
        ST_WARMUP = 2'b00,
        ST_REGULATE = 2'b01,
        ST_FAULT = 2'b10
    } sup_state_t;
endpackage

// ### include/fuser_timer_if.sv
// interface between the supervisor and its persistence timer
`timescale 1ns/1ps
interface fuser_timer_if #(parameter int CNT_W = 32);
    logic             run;
    logic [CNT_W-1:0] limit;
    logic             expired;
    modport ctrl  (output run, output limit, input expired);
    modport timer (input run, input limit, output expired);
endinterface

// ### rtl/fuser_persist_timer.sv
// persistence timer: expires when run stays high past the limit
`timescale 1ns/1ps
module fuser_persist_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic    mclk_i,
    input  wire logic    srst_i,
    input  wire logic    ce_i,
    fuser_timer_if.timer tmr
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire              at_limit = (cnt_q >= tmr.limit);

    // counter clears whenever condition drops, saturates at limit
    assign cnt_d = !tmr.run ? '0 : (at_limit ? cnt_q : cnt_q + 1'b1);
    assign tmr.expired = tmr.run && at_limit;

    // count register
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ### rtl/fuser_temperature_supervisor.sv
// fuser heater regulation and fault supervision
`timescale 1ns/1ps
`include "fuser_map.svh"
module fuser_temperature_supervisor #(
    parameter int                      TEMP_W    = `FUSER_TEMP_W,
    parameter logic [TEMP_W-1:0]       SETPOINT  = `FUSER_SETPOINT_DEF,
    parameter logic [TEMP_W-1:0]       OVERHEAT  = `FUSER_OVERHEAT_DEF,
    parameter logic [`FUSER_CNT_W-1:0] OVER_CYC  = `FUSER_OVER_CYC_DEF,
    parameter logic [`FUSER_CNT_W-1:0] WARM_CYC  = `FUSER_WARM_CYC_DEF,
    parameter logic [`FUSER_CNT_W-1:0] UNDER_CYC = `FUSER_UNDER_CYC_DEF,
    parameter logic [`FUSER_CNT_W-1:0] ABOVE_CYC = `FUSER_ABOVE_CYC_DEF
) (
    input  wire logic                   mclk_i,
    input  wire logic                   srst_i,
    input  wire logic                   ce_i,
    input  wire logic [TEMP_W-1:0]      roller_temp_i,
    input  wire logic                   temp_valid_i,
    input  wire logic                   thermistor_fault_i,
    input  wire logic                   hw_overheat_cut_i,
    output logic                        heater_on_n_o,
    output logic                        power_relay_on_o,
    output logic                        ac_cut_off_o,
    output logic                        printer_stop_o,
    output logic                        fault_o,
    output logic [`FUSER_ERR_W-1:0]     err_code_o,
    output logic                        warm_ready_o
);
    // parameter checks
    initial begin
        if (TEMP_W < 2 || TEMP_W > 16) begin
            $error("fuser supervisor: TEMP_W out of range");
        end
        if (SETPOINT >= OVERHEAT) begin
            $error("fuser supervisor: set point must be below overheat limit");
        end
        if (OVER_CYC == '0 || WARM_CYC == '0 || UNDER_CYC == '0 || ABOVE_CYC == '0) begin
            $error("fuser supervisor: time limits must be nonzero");
        end
    end

    // two-flop synchronisers for the external inputs
    logic [TEMP_W+2:0] sync1_q;
    logic [TEMP_W+2:0] sync2_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= {temp_valid_i, thermistor_fault_i, hw_overheat_cut_i, roller_temp_i};
            sync2_q <= sync1_q;
        end
    end

    wire              vld_s  = sync2_q[TEMP_W+2];
    wire              terr_s = sync2_q[TEMP_W+1];
    wire              hwc_s  = sync2_q[TEMP_W];
    wire [TEMP_W-1:0] samp_s = sync2_q[TEMP_W-1:0];

    // held converter reading; ignored until first valid sample
    logic [TEMP_W-1:0] temp_q;
    logic              have_q;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            temp_q <= '0;
            have_q <= 1'b0;
        end else if (ce_i && vld_s) begin
            temp_q <= samp_s;
            have_q <= 1'b1;
        end
    end

    // comparisons on the digitized reading
    wire below_sp  = have_q && (temp_q < SETPOINT);
    wire above_sp  = have_q && (temp_q > SETPOINT);
    wire at_limit  = have_q && (temp_q >= OVERHEAT);

    fuser_pkg::sup_state_t state_q;
    fuser_pkg::sup_state_t state_d;
    logic [`FUSER_ERR_W-1:0] err_q;
    logic [`FUSER_ERR_W-1:0] err_d;
    logic                    heat_q;

    // persistence timers
    fuser_timer_if #(.CNT_W(`FUSER_CNT_W)) t_over ();
    fuser_timer_if #(.CNT_W(`FUSER_CNT_W)) t_warm ();
    fuser_timer_if #(.CNT_W(`FUSER_CNT_W)) t_under ();
    fuser_timer_if #(.CNT_W(`FUSER_CNT_W)) t_above ();

    wire regulating = (state_q == fuser_pkg::ST_REGULATE);
    assign t_over.run    = (state_q != fuser_pkg::ST_FAULT) && at_limit;
    assign t_over.limit  = OVER_CYC;
    assign t_warm.run    = (state_q == fuser_pkg::ST_WARMUP);
    assign t_warm.limit  = WARM_CYC;
    assign t_under.run   = regulating && below_sp;
    assign t_under.limit = UNDER_CYC;
    assign t_above.run   = regulating && above_sp;
    assign t_above.limit = ABOVE_CYC;

    fuser_persist_timer #(.CNT_W(`FUSER_CNT_W)) u_t_over (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .tmr(t_over.timer)
    );
    fuser_persist_timer #(.CNT_W(`FUSER_CNT_W)) u_t_warm (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .tmr(t_warm.timer)
    );
    fuser_persist_timer #(.CNT_W(`FUSER_CNT_W)) u_t_under (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .tmr(t_under.timer)
    );
    fuser_persist_timer #(.CNT_W(`FUSER_CNT_W)) u_t_above (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .tmr(t_above.timer)
    );

    // fault code selection, fixed priority
    wire [`FUSER_ERR_W-1:0] new_err =
        terr_s            ? `FUSER_ERR_SENSOR :
        hwc_s             ? `FUSER_ERR_HWOVER :
        t_over.expired    ? `FUSER_ERR_OVERTO :
        at_limit          ? `FUSER_ERR_LIMIT  :
        t_warm.expired    ? `FUSER_ERR_WARMUP :
        t_under.expired   ? `FUSER_ERR_UNDER  :
        t_above.expired   ? `FUSER_ERR_OVERSP :
                            `FUSER_ERR_NONE;
    wire any_fault = (new_err != `FUSER_ERR_NONE);

    // supervisor next state; fault latches until reset
    always_comb begin
        state_d = state_q;
        err_d   = err_q;
        unique case (state_q)
            fuser_pkg::ST_WARMUP: begin
                if (any_fault) begin
                    state_d = fuser_pkg::ST_FAULT;
                    err_d   = new_err;
                end else if (have_q && !below_sp) begin
                    state_d = fuser_pkg::ST_REGULATE;
                end
            end
            fuser_pkg::ST_REGULATE: begin
                if (any_fault) begin
                    state_d = fuser_pkg::ST_FAULT;
                    err_d   = new_err;
                end
            end
            fuser_pkg::ST_FAULT: begin
                state_d = fuser_pkg::ST_FAULT;
            end
            default: begin
                state_d = fuser_pkg::ST_FAULT;
                err_d   = `FUSER_ERR_LIMIT;
            end
        endcase
    end

    // state and error code registers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= fuser_pkg::ST_WARMUP;
            err_q   <= `FUSER_ERR_NONE;
        end else if (ce_i) begin
            state_q <= state_d;
            err_q   <= err_d;
        end
    end

    // on/off regulation around the set point
    wire heat_d = !any_fault && (state_q != fuser_pkg::ST_FAULT) && have_q
                  && (temp_q < SETPOINT);
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            heat_q <= 1'b0;
        end else if (ce_i) begin
            heat_q <= heat_d;
        end
    end

    // outputs; relay drops while cut-off, stop and fault rise with the fault state
    wire faulted = (state_q == fuser_pkg::ST_FAULT);
    assign heater_on_n_o    = !heat_q;
    assign power_relay_on_o = !faulted;
    assign ac_cut_off_o     = faulted;
    assign printer_stop_o   = faulted;
    assign fault_o          = faulted;
    assign err_code_o       = err_q;
    assign warm_ready_o     = regulating;

    // assertions
    sequence s_sensor_seen;
        ce_i && terr_s && !faulted;
    endsequence
    sequence s_fault_held;
        faulted && (err_q == `FUSER_ERR_SENSOR) && heater_on_n_o;
    endsequence

    a_sensor_open_code: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_sensor_seen |=> s_fault_held)
        else $error("sensor fault not latched");
    a_hw_cut_relay: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && hwc_s && !terr_s && !faulted) |=> (!power_relay_on_o
            && err_q == `FUSER_ERR_HWOVER && printer_stop_o))
        else $error("hardware cut did not open relay");
    a_limit_stop: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && at_limit) |=> printer_stop_o && !power_relay_on_o)
        else $error("overheat limit did not stop printer");
    a_fault_latched: assert property (@(posedge mclk_i) disable iff (srst_i)
        faulted |=> faulted && $stable(err_q))
        else $error("fault released before reset");
    a_heater_off_fault: assert property (@(posedge mclk_i) disable iff (srst_i)
        faulted [*2] |-> heater_on_n_o && ac_cut_off_o)
        else $error("heater on while faulted");
    a_heat_below_sp: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && have_q && temp_q < SETPOINT && !any_fault && !faulted)
            |=> !heater_on_n_o)
        else $error("heater not on below set point");
    a_heat_off_above: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && have_q && temp_q >= SETPOINT) |=> heater_on_n_o)
        else $error("heater on at or above set point");
    a_code_nonzero: assert property (@(posedge mclk_i) disable iff (srst_i)
        faulted |-> err_q != `FUSER_ERR_NONE)
        else $error("fault without error code");
    a_warmup_timeout: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && t_warm.expired && !terr_s && !hwc_s && !at_limit && !faulted)
            |=> err_q == `FUSER_ERR_WARMUP)
        else $error("warm-up timeout not reported");
    a_under_timeout: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && t_under.expired && !faulted && !terr_s && !hwc_s)
            |=> err_q == `FUSER_ERR_UNDER)
        else $error("under temperature not reported");
    a_above_timeout: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && t_above.expired && !faulted && !terr_s && !hwc_s && !at_limit)
            |=> err_q == `FUSER_ERR_OVERSP)
        else $error("over set point not reported");
    a_read_digital: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && vld_s) |=> temp_q == $past(samp_s))
        else $error("reading not captured");

    // pin-to-output latency checks; two sync stages, one state edge
    // a cut pin held over the two sync stages must fault on the following edge
    sequence s_pin_open_held;
        ce_i && thermistor_fault_i && !faulted ##1 ce_i && thermistor_fault_i;
    endsequence
    // comparator trip held over the same two sync stages
    sequence s_pin_trip_held;
        ce_i && hw_overheat_cut_i && !faulted ##1 ce_i && hw_overheat_cut_i;
    endsequence
    // the edge on which the synced level reaches the state register
    sequence s_state_edge;
        ce_i;
    endsequence

    a_sensor_pin_latency: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_pin_open_held ##1 s_state_edge |=> fault_o && !power_relay_on_o)
        else $error("open sensor pin did not fault in time");
    a_trip_pin_latency: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_pin_trip_held ##1 s_state_edge |=> fault_o && printer_stop_o)
        else $error("comparator trip did not fault in time");

    // any pending fault must drop the heater on the very edge it latches
    a_heat_drop_fault: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && any_fault) |=> heater_on_n_o)
        else $error("heater left on with fault pending");

    // no heating until a converter sample has been taken
    a_heat_need_sample: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && !have_q) |=> heater_on_n_o)
        else $error("heater on without a reading");

    // leaving warm-up once the set point is reached without a fault
    a_warm_to_ready: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ce_i && state_q == fuser_pkg::ST_WARMUP && have_q && !below_sp && !any_fault)
            |=> warm_ready_o && !fault_o)
        else $error("set point reached but not regulating");

    // clock enable low freezes every state register
    a_ce_freeze_all: assert property (@(posedge mclk_i) disable iff (srst_i)
        !ce_i |=> $stable(state_q) && $stable(err_q) && $stable(heat_q) && $stable(temp_q))
        else $error("state moved while clock enable low");

    // reset returns the supervisor to a quiet, unfaulted warm-up
    a_reset_quiet: assert property (@(posedge mclk_i)
        srst_i |=> !fault_o && err_code_o == `FUSER_ERR_NONE && heater_on_n_o
            && power_relay_on_o && !warm_ready_o)
        else $error("reset did not clear supervisor");

    // the error code only changes on the edge that enters the fault state
    a_code_with_fault: assert property (@(posedge mclk_i) disable iff (srst_i)
        (!faulted && !$stable(err_q)) |-> faulted)
        else $error("error code changed without fault");
endmodule
